// ### pkg/pdm_pkg.sv
package pdm_pkg;

    // Register offsets on the plain register port.
    localparam logic [3:0] OFF_CPU_CTRL_STAT = 4'h0;
    localparam logic [3:0] OFF_PLL_CTRL_STAT = 4'h1;
    localparam logic [3:0] OFF_SLEEP_STATUS  = 4'h2;
    localparam logic [3:0] OFF_IRQ_ENABLE    = 4'h3;

    // Field positions.
    localparam int SLEEP_FIELD_LSB   = 10;
    localparam int SLEEP_FIELD_MSB   = 15;
    localparam int GIE_BIT           = 0;
    localparam int NONMASKABLE_ENABLE_BIT_BIT          = 1;
    localparam int PLL_ENABLE_BIT    = 0;

    // Power-down select codes.
    localparam logic [5:0] CODE_NONE        = 6'h00;
    localparam logic [5:0] CODE_LIGHT_EN    = 6'h09;
    localparam logic [5:0] CODE_LIGHT_ANY   = 6'h11;
    localparam logic [5:0] CODE_CLOCK_HALT  = 6'h1A;
    localparam logic [5:0] CODE_PLL_IN_STOP = 6'h1C;

    // Reset values.
    localparam logic [31:0] RST_CPU_CTRL_STAT = 32'h0000_0000;
    localparam logic        RST_PLL_ENABLE    = 1'b1;
    localparam logic [15:0] RST_IRQ_ENABLE    = 16'h0000;

    // Light sleep takes effect eight to nine cycles after the write.
    localparam int LIGHT_DELAY_CYC = 8;

    typedef enum logic [2:0] {
        PDM_RUN,
        PDM_ARMING,
        PDM_LIGHT,
        PDM_HALT,
        PDM_PLL_STOP
    } pdm_state_e;

    typedef struct packed {
        logic [3:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } pdm_bus_s;

    typedef struct packed {
        logic cpu_clk_en;
        logic pll_out_en;
        logic pll_in_en;
        logic dma_clk_en;
        logic irq_clk_en;
    } pdm_clk_s;

endpackage

// ### hw/pdm_power_down.sv
// What this block does
// - The sleep_mode_field sits in bits 15 to 10 of cpu_control_status.
// - Code 000000 runs normally; codes other than the four are reserved.
// - Code 001001 enters light sleep, woken only by an enabled interrupt.
// - Code 010001 enters light sleep, woken by any interrupt.
// - Codes 011010 and 011100 enter deep modes left only by device reset.
// - A non-enabled wake resumes at the sleep point with no service.
// - An enabled wake runs the service routine, then resumes.
// - Service runs only if global and nonmaskable enables are both set.
// - Light sleep gates CPU clocks but keeps interrupt logic clocked.
// - Enhanced DMA clock keeps running during light sleep.
// - Clock-halt sleep stops the PLL output clock tree.
// - Deep modes keep register and RAM contents and freeze outputs.
// - PLL-input-stop stops the PLL input; reset wake must relock PLL.
// - Asynchronous peripherals may still toggle outputs in deep modes.
// - With pll_enable_bit at 0 the deep modes stop nothing.
// - Light sleep takes effect eight to nine cycles after the write.
//
// Chosen here: the strobed register port and the address map.
module pdm_power_down (
    // Clock and reset.
    input  wire logic               clk,
    input  wire logic               rst_n,
    // Register port.
    input  wire pdm_pkg::pdm_bus_s  bus,
    output logic [31:0]             rdata,
    // Interrupt sources, already in this clock domain.
    input  wire logic [15:0]        irq_pending,
    // Clock generator controls.
    output pdm_pkg::pdm_clk_s       clk_ctrl,
    output logic                    pll_relock_req,
    // CPU wake report.
    output logic                    wake_pulse,
    output logic                    wake_service
);

    logic [31:0]          csr_ff;
    logic [15:0]          ier_ff;
    logic                 pll_en_ff;
    pdm_pkg::pdm_state_e  state_ff;
    logic [3:0]           delay_ff;
    logic [5:0]           armed_code_ff;
    logic                 stopped_in_ff;
    logic [31:0]          rdata_ff;
    pdm_pkg::pdm_clk_s    clk_ff;
    logic                 relock_ff;
    logic                 wake_ff;
    logic                 service_ff;

    logic [5:0]           field;
    logic                 field_wr;
    logic                 en_irq;
    logic                 any_irq;
    logic                 wake_now;
    logic                 nxt_service;

    function automatic logic is_light(input logic [5:0] code);
        return code == pdm_pkg::CODE_LIGHT_EN ||
               code == pdm_pkg::CODE_LIGHT_ANY;
    endfunction

    function automatic logic is_deep(input logic [5:0] code);
        return code == pdm_pkg::CODE_CLOCK_HALT ||
               code == pdm_pkg::CODE_PLL_IN_STOP;
    endfunction

    assign field    = bus.wdata[pdm_pkg::SLEEP_FIELD_MSB:
                                pdm_pkg::SLEEP_FIELD_LSB];
    assign field_wr = bus.wr && bus.addr == pdm_pkg::OFF_CPU_CTRL_STAT;
    assign en_irq   = |(irq_pending & ier_ff);
    assign any_irq  = |irq_pending;
    // Wake choice follows the code that armed the sleep.
    assign wake_now = (armed_code_ff == pdm_pkg::CODE_LIGHT_EN)
                    ? en_irq : any_irq;
    assign nxt_service = en_irq &&
                         csr_ff[pdm_pkg::GIE_BIT] &&
                         ier_ff[pdm_pkg::NONMASKABLE_ENABLE_BIT_BIT];

    // Control status register; the field reads back as written.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            csr_ff <= pdm_pkg::RST_CPU_CTRL_STAT;
        end else if (field_wr) begin
            csr_ff <= bus.wdata;
        end else if (wake_ff) begin
            // Waking clears the field so the CPU does not re-enter sleep.
            csr_ff[pdm_pkg::SLEEP_FIELD_MSB:pdm_pkg::SLEEP_FIELD_LSB]
                <= pdm_pkg::CODE_NONE;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ier_ff <= pdm_pkg::RST_IRQ_ENABLE;
        end else if (bus.wr && bus.addr == pdm_pkg::OFF_IRQ_ENABLE) begin
            ier_ff <= bus.wdata[15:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pll_en_ff <= pdm_pkg::RST_PLL_ENABLE;
        end else if (bus.wr && bus.addr == pdm_pkg::OFF_PLL_CTRL_STAT
                     && state_ff == pdm_pkg::PDM_RUN) begin
            pll_en_ff <= bus.wdata[pdm_pkg::PLL_ENABLE_BIT];
        end
    end

    // Sequencer. Deep states have no exit but reset; nothing in the
    // core still clocks once the tree stops, so that is the only way out.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff      <= pdm_pkg::PDM_RUN;
            delay_ff      <= 4'h0;
            armed_code_ff <= pdm_pkg::CODE_NONE;
        end else begin
            case (state_ff)
                pdm_pkg::PDM_RUN: begin
                    // Reserved and zero codes leave the CPU running.
                    if (field_wr &&
                        (is_light(field) || is_deep(field))) begin
                        state_ff      <= pdm_pkg::PDM_ARMING;
                        armed_code_ff <= field;
                        delay_ff      <= 4'h1;
                    end
                end
                pdm_pkg::PDM_ARMING: begin
                    if (delay_ff == 4'(pdm_pkg::LIGHT_DELAY_CYC - 1)) begin
                        if (is_light(armed_code_ff)) begin
                            state_ff <= pdm_pkg::PDM_LIGHT;
                        end else if (!pll_en_ff) begin
                            // Bypassed PLL: clocks come straight in.
                            state_ff <= pdm_pkg::PDM_RUN;
                        end else if (armed_code_ff ==
                                     pdm_pkg::CODE_CLOCK_HALT) begin
                            state_ff <= pdm_pkg::PDM_HALT;
                        end else begin
                            state_ff <= pdm_pkg::PDM_PLL_STOP;
                        end
                    end else begin
                        delay_ff <= delay_ff + 4'h1;
                    end
                end
                pdm_pkg::PDM_LIGHT: begin
                    if (wake_now) begin
                        state_ff <= pdm_pkg::PDM_RUN;
                    end
                end
                pdm_pkg::PDM_HALT: state_ff <= pdm_pkg::PDM_HALT;
                pdm_pkg::PDM_PLL_STOP: state_ff <= pdm_pkg::PDM_PLL_STOP;
                default: state_ff <= pdm_pkg::PDM_RUN;
            endcase
        end
    end

    // Clock enables toward the clock generator.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clk_ff <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
        end else begin
            clk_ff.cpu_clk_en <= state_ff == pdm_pkg::PDM_RUN ||
                                 state_ff == pdm_pkg::PDM_ARMING;
            clk_ff.irq_clk_en <= state_ff != pdm_pkg::PDM_HALT &&
                                 state_ff != pdm_pkg::PDM_PLL_STOP;
            clk_ff.dma_clk_en <= state_ff != pdm_pkg::PDM_HALT &&
                                 state_ff != pdm_pkg::PDM_PLL_STOP;
            // Freezing the tree keeps all state and holds the pins.
            // Logic clocked from outside may still toggle here.
            clk_ff.pll_out_en <= state_ff != pdm_pkg::PDM_HALT &&
                                 state_ff != pdm_pkg::PDM_PLL_STOP;
            clk_ff.pll_in_en  <= state_ff != pdm_pkg::PDM_PLL_STOP;
        end
    end

    // The PLL-input stop is remembered across the waking reset by the
    // clock generator's own reset hold; here it is flagged while the stop
    // lasts and shown as a relock request until reset clears it.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stopped_in_ff <= 1'b0;
            relock_ff     <= 1'b0;
        end else begin
            stopped_in_ff <= state_ff == pdm_pkg::PDM_PLL_STOP;
            relock_ff     <= state_ff == pdm_pkg::PDM_PLL_STOP;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wake_ff    <= 1'b0;
            service_ff <= 1'b0;
        end else begin
            wake_ff    <= state_ff == pdm_pkg::PDM_LIGHT && wake_now;
            service_ff <= state_ff == pdm_pkg::PDM_LIGHT && wake_now
                          && nxt_service;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff <= 32'h0000_0000;
        end else if (bus.rd) begin
            case (bus.addr)
                pdm_pkg::OFF_CPU_CTRL_STAT: rdata_ff <= csr_ff;
                pdm_pkg::OFF_PLL_CTRL_STAT:
                    rdata_ff <= {31'h0, pll_en_ff};
                pdm_pkg::OFF_SLEEP_STATUS:
                    rdata_ff <= {26'h0, stopped_in_ff, 2'h0,
                                 3'(state_ff)};
                pdm_pkg::OFF_IRQ_ENABLE:
                    rdata_ff <= {16'h0, ier_ff};
                default: rdata_ff <= 32'h0000_0000;
            endcase
        end else begin
            rdata_ff <= 32'h0000_0000;
        end
    end

    assign rdata          = rdata_ff;
    assign clk_ctrl       = clk_ff;
    assign pll_relock_req = relock_ff;
    assign wake_pulse     = wake_ff;
    assign wake_service   = service_ff;

endmodule

// ### dv/pdm_power_down_properties.sv
module pdm_power_down_properties (
    // Watched ports.
    input wire logic              clk,
    input wire logic              rst_n,
    input wire pdm_pkg::pdm_bus_s bus,
    input wire logic [31:0]       rdata,
    input wire logic [15:0]       irq_pending,
    input wire pdm_pkg::pdm_clk_s clk_ctrl,
    input wire logic              pll_relock_req,
    input wire logic              wake_pulse,
    input wire logic              wake_service
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic       pll_ff;
    logic       go;
    logic       lc;
    logic       dc;
    logic       irq;
    logic [5:0] c;
    assign c = bus.wdata[15:10];
    assign go = bus.wr && bus.addr == 4'h0 && clk_ctrl == 5'h1F;
    assign lc = c == 6'h09 || c == 6'h11;
    assign dc = c == 6'h1A || c == 6'h1C;
    assign irq = |irq_pending;
    // Mirrors the PLL enable so that bypassed deep requests are told apart.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            pll_ff <= 1'b1;
        else if (bus.wr && bus.addr == 4'h1)
            pll_ff <= bus.wdata[0];
    end
    a_light_entry:
    assert property (go && lc |-> ##1 (clk_ctrl == 5'h1F)[*7]
        ##[2:3] clk_ctrl == 5'h0F) else $error("light entry wrong");
    a_halt_entry:
    assert property (go && pll_ff && c == 6'h1A |-> ##1
        (clk_ctrl == 5'h1F)[*7] ##[2:3] clk_ctrl == 5'h04)
        else $error("halt entry wrong");
    a_stop_entry:
    assert property (go && pll_ff && c == 6'h1C |-> ##1
        (clk_ctrl == 5'h1F)[*7] ##[2:3] clk_ctrl == 5'h00 ##[1:2]
        pll_relock_req) else $error("pll stop entry wrong");
    a_no_stop:
    assert property (go && !lc && !(pll_ff && dc) |-> ##1
        (clk_ctrl == 5'h1F)[*8]) else $error("clocks stopped wrongly");
    a_deep_hold:
    assert property (!clk_ctrl.pll_out_en |=> !clk_ctrl.pll_out_en
        && !wake_pulse) else $error("deep mode left without reset");
    a_light_domains:
    assert property (!clk_ctrl.cpu_clk_en && clk_ctrl.pll_out_en |->
        clk_ctrl.irq_clk_en && clk_ctrl.dma_clk_en)
        else $error("irq or dma clock gated in light sleep");
    a_wake_resume:
    assert property ($rose(clk_ctrl.cpu_clk_en) |-> $past(wake_pulse))
        else $error("cpu clock back without wake pulse");
    a_service_cause:
    assert property (wake_service |-> wake_pulse && $past(irq))
        else $error("service without wake or interrupt");
    a_reset_clocks:
    assert property ($rose(rst_n) |-> clk_ctrl == 5'h1F && rdata == 32'h0)
        else $error("reset left clocks stopped");
    cover property (go && lc);
    cover property (wake_service);
    cover property (pll_relock_req);
endmodule

bind pdm_power_down pdm_power_down_properties pdm_power_down_properties_i (
    .clk, .rst_n, .bus, .rdata, .irq_pending, .clk_ctrl, .pll_relock_req,
    .wake_pulse, .wake_service);

// ### dv/pdm_irq_src.sv
module pdm_irq_src (
    // Clock, reset and bench command.
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [15:0] raise,
    // Request levels toward the block.
    output logic [15:0]      irq_pending
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] pend_ff;
    logic [2:0]  hold_ff;
    assign irq_pending = pend_ff;
    // A source withdraws after five cycles, so a wake must not lean on it.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_ff <= 16'h0000;
            hold_ff <= 3'h0;
        end else if (raise != 16'h0000) begin
            pend_ff <= raise;
            hold_ff <= 3'h4;
        end else if (hold_ff != 3'h0) begin
            hold_ff <= hold_ff - 3'h1;
        end else begin
            pend_ff <= 16'h0000;
        end
    end
endmodule

// ### dv/tb_power_down_mode_logic.sv
module tb_power_down_mode_logic;
    timeunit 1ns;
    timeprecision 1ps;
    logic              clk = 1'b0;
    logic              rst_n = 1'b0;
    pdm_pkg::pdm_bus_s bus = '0;
    logic [15:0]       raise = 16'h0000;
    logic [31:0]       rdata;
    logic [15:0]       irq_pending;
    pdm_pkg::pdm_clk_s clk_ctrl;
    logic              pll_relock_req;
    logic              wake_pulse;
    logic              wake_service;
    logic [31:0]       got;
    logic [5:0]        c;
    int                num_errors = 0;
    int                n_tests = 0;
    int                seed = 77897;
    int                i;
    always #12.5 clk = ~clk;
    pdm_power_down pdm_power_down_i (.clk, .rst_n, .bus, .rdata,
        .irq_pending, .clk_ctrl, .pll_relock_req, .wake_pulse, .wake_service);
    pdm_irq_src pdm_irq_src_i (.clk, .rst_n, .raise, .irq_pending);
    // Reference: clock enables expected for a code once it has settled.
    function automatic logic [4:0] model(input int code, input int pll);
        if (code == 6'h1A && pll != 0) return 5'h04;
        if (code == 6'h1C && pll != 0) return 5'h00;
        if (code == 6'h09 || code == 6'h11) return 5'h0F;
        return 5'h1F;
    endfunction
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge clk);
        bus <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
        #1 got = rdata;
    endtask
    task automatic pulse(input logic [15:0] m);
        @(posedge clk);
        raise <= m;
        @(posedge clk);
        raise <= 16'h0000;
    endtask
    task automatic wake(input logic es);
        for (int k = 0; k < 20 && wake_pulse !== 1'b1; k++) step(1);
        chk("wake_pulse", 1'b1, wake_pulse);
        chk("wake_service", es, wake_service);
        // The CPU clock comes back one cycle after the wake pulse.
        step(1);
        chk("cpu_clk_en", 1'b1, clk_ctrl.cpu_clk_en);
    endtask
    task automatic light(input logic [5:0] cd, input logic g, input logic n);
        wr(4'h3, {29'h0, 1'b1, n, 1'b0});
        wr(4'h0, {16'h0, cd, 9'h0, g});
        step(10);
        chk("light clocks", model(cd, 1), clk_ctrl);
        pulse(16'h0020);
        if (cd == 6'h11) begin
            wake(1'b0);
        end else begin
            step(6);
            chk("still asleep", model(cd, 1), clk_ctrl);
            pulse(16'h0004);
            wake(g & n);
        end
        step(6);
        rd(4'h0);
        chk("field cleared", 6'h00, got[15:10]);
        $display("light sleep code %h done", cd);
    endtask
    task automatic deep(input logic [5:0] cd);
        wr(4'h1, 32'h1);
        wr(4'h0, {16'h0, cd, 10'h0});
        step(10);
        chk("deep clocks", model(cd, 1), clk_ctrl);
        pulse(16'h0024);
        step(4);
        chk("deep stays", model(cd, 1), clk_ctrl);
        chk("relock", cd == 6'h1C, pll_relock_req);
        rst_n <= 1'b0;
        step(2);
        rst_n <= 1'b1;
        step(1);
        chk("reset clocks", 5'h1F, clk_ctrl);
        rd(4'h0);
        chk("csr after reset", 32'h0, got);
        $display("deep code %h done", cd);
    endtask
    task automatic conclude();
        $display("counts: %0d checks, %0d mismatches", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Whole run is well under a thousand cycles; this leaves ample slack.
    initial begin
        #100000;
        num_errors++;
        conclude();
    end
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        step(1);
        chk("reset clocks", 5'h1F, clk_ctrl);
        rd(4'h1);
        chk("pll enable", 1'b1, got[0]);
        rd(4'h7);
        chk("unmapped", 32'h0, got);
        for (i = 0; i < 4; i++) begin
            c = 6'($random(seed)) & 6'h1F;
            if (c inside {6'h09, 6'h11, 6'h1A, 6'h1C}) c = 6'h1F;
            wr(4'h0, {16'h0, c, 10'h0});
            step(10);
            chk("reserved code", model(c, 1), clk_ctrl);
        end
        $display("reserved codes done");
        for (i = 0; i < 4; i++) light(6'h09, i[0], i[1]);
        light(6'h11, 1'b1, 1'b1);
        wr(4'h1, 32'h0);
        wr(4'h0, {16'h0, 6'h1A, 10'h0});
        step(10);
        chk("bypassed halt", model(6'h1A, 0), clk_ctrl);
        $display("bypass done");
        deep(6'h1A);
        deep(6'h1C);
        conclude();
    end
endmodule
